// ==== wdt_pkg.sv ====
// Overview of operation
// - Retriggerable one-shot; terminal count pulses a processor core reset.
// - Timer stays idle until the first supervision instruction enables it.
// - Each later supervision instruction restarts the time-out period.
// - Counter advances on the RC oscillator, not on the crystal clock.
// - The supervision instruction updates the zero, sign and overflow flags.
// - Mode register writable only in first 120 clocks after first instruction.
// - After that window every mode register write is ignored until re-armed.
// - Mode register is write-only; reads never return its contents.
// - Stop-wake recovery keeps the mode register contents.
// - Bit 3 selects whether counting continues during stop mode.
// - Bit 2 selects whether counting continues during halt mode.
// - Bits 1:0 pick minimum time-out of 5, 10, 20 or 80 ms.
//
// Purpose: constants and types for the supervision timer.
// Assumes: one processor clock at 250 MHz; RC oscillator arrives as a plain level.
// Notes: tick counts derive from the oscillator rate parameter of the top.
package wdt_pkg;

    localparam logic [11:0] MODE_ADDR = 12'hF0F;
    localparam int MODE_STOP_BIT = 3;
    localparam int MODE_HALT_BIT = 2;
    localparam logic [3:0] MODE_RESET = 4'hD;
    localparam int WINDOW_XTAL_CLOCKS = 120;
    localparam int RC_HZ_DEFAULT = 100000;
    localparam int TIMEOUT0_MS = 5;
    localparam int TIMEOUT1_MS = 10;
    localparam int TIMEOUT2_MS = 20;
    localparam int TIMEOUT3_MS = 80;

    typedef struct packed {
        logic stop_run;
        logic halt_run;
        logic [1:0] tsel;
    } wdt_mode_type;

    typedef struct packed {
        logic we;
        logic zero;
        logic sign;
        logic overflow;
    } wdt_flags_type;

    typedef enum logic [1:0] {
        WIN_WAIT = 2'b00,
        WIN_OPEN = 2'b01,
        WIN_SHUT = 2'b11
    } wdt_win_type;

endpackage : wdt_pkg

// ==== wdt_top.sv ====
// Purpose: supervision timer with mode register writable only in its write window.
// Assumes: all inputs synchronous to clock except rc_osc; strobes are one cycle.
// Notes: stop_wake_recovery re-arms the write window but keeps the mode.
`timescale 1ns/1ps
module wdt_top
#(
    parameter int RC_HZ = wdt_pkg::RC_HZ_DEFAULT,
    parameter int CNT_W = 16
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic rc_osc,
    input wire logic instr_exec,
    input wire logic sup_instr,
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic stop_wake_recovery,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    output logic core_reset,
    output wdt_pkg::wdt_flags_type flags,
    output logic timer_enabled
);
    import wdt_pkg::*;

    // Synchroniser depth; only the last two stages feed the edge detector
    localparam int SYNC_DEPTH = 3;
    localparam logic [7:0] WIN_LAST = 8'(WINDOW_XTAL_CLOCKS - 1);

    // Least times round up to whole oscillator ticks
    function automatic logic [CNT_W-1:0] ticks(input int ms);
        ticks = CNT_W'((RC_HZ * ms + 999) / 1000);
    endfunction : ticks

    // Register port decode, shared by the write and read paths
    function automatic logic is_mode_addr(input logic [11:0] a);
        is_mode_addr = (a == MODE_ADDR);
    endfunction : is_mode_addr

    // Taps fixed at elaboration, so no divider is built
    localparam logic [CNT_W-1:0] LIMIT0 = ticks(TIMEOUT0_MS);
    localparam logic [CNT_W-1:0] LIMIT1 = ticks(TIMEOUT1_MS);
    localparam logic [CNT_W-1:0] LIMIT2 = ticks(TIMEOUT2_MS);
    localparam logic [CNT_W-1:0] LIMIT3 = ticks(TIMEOUT3_MS);

    wdt_mode_type mode_q, mode_d;
    wdt_win_type win_q, win_d;
    logic [7:0] win_cnt_q, win_cnt_d;
    logic en_q, en_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [SYNC_DEPTH-1:0] rc_sync_q;
    logic rst_q, rst_d;
    wdt_flags_type flags_q, flags_d;
    logic [7:0] rdata_q, rdata_d;
    logic [CNT_W-1:0] limit;
    logic tick;
    logic halt_block;
    logic stop_block;
    logic run;
    logic mode_hit;
    logic mode_wr;
    logic mode_rd;

    // oscillator synchroniser
    // Shift chain: only stage 1 reads stage 0, which may be metastable
    always_ff @(posedge clock)
    begin
        rc_sync_q <= {rc_sync_q[SYNC_DEPTH-2:0], rc_osc};
    end

    // oscillator edges
    // Counting runs on clock; the oscillator only paces it
    assign tick = rc_sync_q[SYNC_DEPTH-2] & ~rc_sync_q[SYNC_DEPTH-1];

    always_comb
    begin
        case (mode_q.tsel)
            2'b00: limit = LIMIT0;
            2'b01: limit = LIMIT1;
            2'b10: limit = LIMIT2;
            default: limit = LIMIT3;
        endcase
    end

    assign halt_block = halt_mode & ~mode_q.halt_run;

    assign stop_block = stop_mode & ~mode_q.stop_run;

    assign run = en_q & ~halt_block & ~stop_block;

    // Address decode
    always_comb
    begin
        if (is_mode_addr(addr))
            mode_hit = 1'b1;
        else
            mode_hit = 1'b0;
    end

    assign mode_wr = wr_stb & mode_hit & (win_q == WIN_OPEN);
    assign mode_rd = rd_stb & is_mode_addr(addr);

    // Write window
    always_comb
    begin
        win_d = win_q;
        win_cnt_d = win_cnt_q;
        case (win_q)
            WIN_WAIT:
            begin
                win_cnt_d = 8'h00;
                if (instr_exec)
                    win_d = WIN_OPEN;
            end
            WIN_OPEN:
            begin
                win_cnt_d = win_cnt_q + 8'h01;
                if (win_cnt_q == WIN_LAST)
                    win_d = WIN_SHUT;
            end
            default:
            begin
                win_cnt_d = win_cnt_q;
                win_d = WIN_SHUT;
            end
        endcase
        if (stop_wake_recovery)
            win_d = WIN_WAIT;
        // Core reset restarts the window like power-on
        if (rst_q)
            win_d = WIN_WAIT;
    end

    // Mode register
    always_comb
    begin
        mode_d = mode_q;
        // Reserved upper bits are not stored
        if (mode_wr)
            mode_d = wdt_mode_type'(wdata[3:0]);
        // Only a core reset, not a recovery, restores the default
        if (rst_q)
            mode_d = wdt_mode_type'(MODE_RESET);
    end

    // Timer and core reset
    always_comb
    begin
        en_d = en_q;
        cnt_d = cnt_q;
        rst_d = 1'b0;
        if (sup_instr)
        begin
            en_d = 1'b1;
            // restart period
            // Restart beats a tick in the same cycle, so a late refresh still counts
            cnt_d = '0;
        end
        else if (run && tick)
        begin
            if (cnt_q >= limit - CNT_W'(1))
            begin
                rst_d = 1'b1;
                cnt_d = '0;
            end
            else
                cnt_d = cnt_q + CNT_W'(1);
        end
        // One-shot: the pulse disarms the timer until the next instruction
        if (rst_q)
        begin
            en_d = 1'b0;
            cnt_d = '0;
        end
    end

    // flag update
    // Flag values are a chosen constant; only the strobe marks the update
    always_comb
    begin
        flags_d = '0;
        if (sup_instr)
        begin
            flags_d.we = 1'b1;
            flags_d.zero = 1'b0;
            flags_d.sign = 1'b0;
            flags_d.overflow = 1'b0;
        end
    end

    // mode register never readable
    // Unmapped reads also return zero, so nothing leaks the mode
    always_comb
    begin
        rdata_d = 8'h00;
        if (mode_rd)
            rdata_d = 8'h00;
    end

    // Window state
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            win_q <= WIN_WAIT;
            win_cnt_q <= 8'h00;
        end
        else
        begin
            win_q <= win_d;
            win_cnt_q <= win_cnt_d;
        end
    end

    // Mode state
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mode_q <= wdt_mode_type'(MODE_RESET);
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    // Timer state
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            en_q <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            en_q <= en_d;
            cnt_q <= cnt_d;
        end
    end

    // Core reset pulse
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rst_q <= 1'b0;
        end
        else
        begin
            rst_q <= rst_d;
        end
    end

    // Flag state
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            flags_q <= '0;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // Read data
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign core_reset = rst_q;
    assign flags = flags_q;
    assign timer_enabled = en_q;

endmodule : wdt_top

// ==== wdt_checker.sv ====
// Purpose: port checks for the supervision timer
// Assumes: one clock domain, srst synchronous
// Notes: mode register is never visible, so only outputs are judged
`timescale 1ns/1ps
module wdt_checker
(
    input wire logic clock,
    input wire logic srst,
    input wire logic sup_instr,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic core_reset,
    input wire wdt_pkg::wdt_flags_type flags,
    input wire logic timer_enabled
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_read_blank: assert property (rd_stb |=> rdata == 8'h00)
        else $error("mode read returned data");
    a_rdata_rest: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("read data without strobe");
    a_flag_set: assert property (sup_instr |=> flags == 4'h8)
        else $error("flags wrong after instruction");
    a_flag_quiet: assert property (!sup_instr |=> !flags.we)
        else $error("flag update without instruction");
    a_enable_arm: assert property (sup_instr |=> timer_enabled)
        else $error("instruction did not arm timer");
    a_idle_silent: assert property (!timer_enabled |=> !core_reset)
        else $error("reset from idle timer");
    a_one_shot: assert property (core_reset |=> !core_reset && !timer_enabled)
        else $error("reset pulse not one shot");
    a_stay_armed: assert property (timer_enabled && !core_reset |=> timer_enabled)
        else $error("timer dropped without reset");
    a_refresh_gap: assert property (sup_instr |=> !core_reset [*8])
        else $error("reset right after refresh");
endmodule : wdt_checker
bind wdt_top wdt_checker i_chk (.clock(clock), .srst(srst), .sup_instr(sup_instr),
    .rd_stb(rd_stb), .rdata(rdata), .core_reset(core_reset), .flags(flags),
    .timer_enabled(timer_enabled));

// ==== testbench.sv ====
// Purpose: directed bench for the supervision timer
// Assumes: RC_HZ 1000, one oscillator tick every 10 clocks
// Notes: wait counts allow for phase and the three flop synchroniser
`timescale 1ns/1ps
module testbench;
    import wdt_pkg::*;
    logic clock = 0, srst = 1, rc_osc = 0, ie = 0, si = 0, hm = 0, sm = 0, swr = 0;
    logic ws = 0, rs = 0, core_reset, ten;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, rdata;
    wdt_flags_type flags;
    int fail_count = 0, n_checks = 0, n, k = 0;
    int lim[4] = '{TIMEOUT0_MS, TIMEOUT1_MS, TIMEOUT2_MS, TIMEOUT3_MS};
    wdt_top #(.RC_HZ(1000)) i_dut (.clock(clock), .srst(srst), .rc_osc(rc_osc),
        .instr_exec(ie), .sup_instr(si), .halt_mode(hm), .stop_mode(sm),
        .stop_wake_recovery(swr), .addr(addr), .wdata(wdata), .wr_stb(ws), .rd_stb(rs),
        .rdata(rdata), .core_reset(core_reset), .flags(flags), .timer_enabled(ten));
    initial forever #2 clock = ~clock;
    always @(posedge clock)
    begin
        k <= (k + 1) % 5;
        if (k == 0) rc_osc <= ~rc_osc;
    end
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    function bit inr(int c, int l);
        return c >= (l - 1) * 10 && c <= l * 10 + 6;
    endfunction : inr
    // Opens the window, writes the mode after gap clocks, then arms
    task arm(input logic [7:0] wd, input int gap);
        @(posedge clock) ie <= 1;
        @(posedge clock) ie <= 0;
        repeat (gap) @(posedge clock);
        ws <= 1;
        addr <= MODE_ADDR;
        wdata <= wd;
        @(posedge clock) ws <= 0;
        si <= 1;
        @(posedge clock) si <= 0;
    endtask : arm
    task wait_rst;
        n = 0;
        while (core_reset !== 1'b1 && n < 1500)
        begin
            @(posedge clock) #1;
            n++;
        end
        if (n == 1500)
        begin
            fail_count++;
            $display("wrong value at %0t: core reset never came", $time);
            test_done;
        end
        repeat (2) @(posedge clock);
    endtask : wait_rst
    task t_idle;
        repeat (200) @(posedge clock);
        chk(ten, 0);
        @(posedge clock) rs <= 1;
        addr <= MODE_ADDR;
        @(posedge clock) addr <= 12'h0FF;
        #1 chk(rdata, 0);
        @(posedge clock) rs <= 0;
        #1 chk(rdata, 0);
        $display("idle test done");
    endtask : t_idle
    task t_tsel;
        for (int t = 0; t < 4; t++)
        begin
            arm(8'h0C | 8'(t), 2);
            wait_rst;
            chk(inr(n, lim[t]), 1);
        end
        $display("time-out select test done");
    endtask : t_tsel
    task t_refresh;
        arm(8'h0D, 2);
        repeat (6)
        begin
            repeat (50) @(posedge clock);
            si <= 1;
            @(posedge clock) si <= 0;
        end
        wait_rst;
        chk(inr(n, 10), 1);
        $display("refresh test done");
    endtask : t_refresh
    task t_window;
        arm(8'h0C, 130);
        wait_rst;
        chk(inr(n, 10), 1);
        arm(8'h0C, 2);
        swr <= 1;
        @(posedge clock) swr <= 0;
        si <= 1;
        @(posedge clock) si <= 0;
        wait_rst;
        chk(inr(n, 5), 1);
        $display("window test done");
    endtask : t_window
    // Halt then stop held with the matching bit clear: no tick may count
    task t_modes;
        for (int i = 0; i < 2; i++)
        begin
            arm(i ? 8'h04 : 8'h08, 2);
            hm <= (i == 0);
            sm <= (i == 1);
            repeat (300) @(posedge clock);
            hm <= 0;
            sm <= 0;
            wait_rst;
            chk(n <= 56, 1);
        end
        $display("low power test done");
    endtask : t_modes
    initial
    begin
        repeat (12) @(posedge clock);
        srst <= 0;
        t_idle;
        t_tsel;
        t_refresh;
        t_window;
        t_modes;
        test_done;
    end
endmodule : testbench
